/* File: include/wcr_pkg.sv */
// Package for the warning and clip signal routing block
package wcr_pkg;
  // ----------------------------------------
  // Register offsets and reset values
  // ----------------------------------------
  localparam logic [7:0] WARN_MASK_LATCHED_OFS = 8'h1F;
  localparam logic [7:0] WARN_MASK_LIVE_OFS    = 8'h20;
  localparam logic [7:0] CLIP_DETECT_CFG_OFS   = 8'h21;
  localparam logic [7:0] WARN_MASK_LATCHED_RST = 8'h04;
  localparam logic [7:0] WARN_MASK_LIVE_RST    = 8'h00;
  localparam logic [7:0] CLIP_DETECT_CFG_RST   = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_CLIP      = 6;
  localparam int BIT_CLOCK     = 5;
  localparam int BIT_SHUTDOWN  = 4;
  localparam int BIT_POWER     = 3;
  localparam int BIT_TEMPWARN  = 2;
  localparam int BIT_FOLDBACK  = 1;
  localparam int BIT_ILIMIT    = 0;
  localparam int BIT_DIAG      = 0;
  localparam int BIT_CLIP_EN   = 6;
  localparam int BIT_LVL_HI    = 5;
  localparam int BIT_LVL_LO    = 4;
  localparam int BIT_C34_GRP2  = 3;
  localparam int BIT_C34_GRP1  = 2;
  localparam int BIT_C12_GRP2  = 1;
  localparam int BIT_C12_GRP1  = 0;
  localparam logic [7:0] LIVE_MASK_USED = 8'h3F;
  localparam logic [7:0] CLIP_CFG_USED  = 8'h7F;
  localparam logic [7:0] LATCH_MASK_USED = 8'h7F;
  // ----------------------------------------
  // Clip threshold codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    CLIP_THD_2PCT  = 2'h0,
    CLIP_THD_5PCT  = 2'h1,
    CLIP_THD_10PCT = 2'h2,
    CLIP_THD_1PCT  = 2'h3
  } wcr_clip_lvl_e;
endpackage : wcr_pkg

/* File: core/wcr_routing.sv */
// Warning signal and clip group routing with its three configuration registers
`timescale 1ns/10ps
module wcr_routing #(
  parameter int NUM_CH = 4
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  clkEn,
  // Register port
  input  wire logic                  regWrEn,
  input  wire logic [7:0]            regAddr,
  input  wire logic [7:0]            regWrData,
  output logic      [7:0]            regRdData,
  // Latched flags
  input  wire logic [NUM_CH-1:0]     clipStored,
  input  wire logic                  invalidClockStored,
  input  wire logic [NUM_CH-1:0]     overtempShutdownFlagStoredCh,
  input  wire logic                  overtempShutdownFlagStored,
  input  wire logic                  batteryUndervoltageFlagStored,
  input  wire logic                  batteryOvervoltageFlagStored,
  input  wire logic                  outputSupplyUndervoltageFlagStored,
  input  wire logic                  outputSupplyOvervoltageFlagStored,
  input  wire logic                  logicSupplyPorFlagStored,
  input  wire logic                  gateDriveSupplyFaultFlagStored,
  input  wire logic [NUM_CH-1:0]     overtempWarningFlagStoredCh,
  input  wire logic                  overtempWarningFlagStored,
  input  wire logic                  gainFoldbackWarningFlagStored,
  input  wire logic [NUM_CH-1:0]     ilimitWarnStored,
  // Live flags
  input  wire logic                  invalidClock,
  input  wire logic [NUM_CH-1:0]     overtempShutdownFlagCh,
  input  wire logic                  overtempShutdownFlag,
  input  wire logic                  batteryUndervoltageFlag,
  input  wire logic                  batteryOvervoltageFlag,
  input  wire logic                  outputSupplyUndervoltageFlag,
  input  wire logic                  outputSupplyOvervoltageFlag,
  input  wire logic                  gateDriveSupplyFaultFlag,
  input  wire logic [NUM_CH-1:0]     overtempWarningFlagCh,
  input  wire logic                  overtempWarningFlag,
  input  wire logic                  gainFoldbackWarningFlag,
  input  wire logic [NUM_CH-1:0]     loadDiagDoneReport,
  // Raw clip detector outputs per channel
  input  wire logic [NUM_CH-1:0]     clipRaw,
  // Pin selection
  input  wire logic                  pinSelWarning,
  input  wire logic                  pinSelGroupOne,
  input  wire logic                  pinSelGroupTwo,
  // Results
  output logic                       warningActive,
  output logic                       clipGroupOne,
  output logic                       clipGroupTwo,
  output logic [NUM_CH-1:0]          channelClip,
  output wcr_pkg::wcr_clip_lvl_e     clipThresholdSelect,
  output logic                       clipDetectEnable,
  output logic                       pinOut,
  output logic                       pinOe
);
  import wcr_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] warnMaskLatched_r;
  logic [7:0] warnMaskLive_r;
  logic [7:0] clipDetectCfg_r;
  logic       warning_r;
  logic       warning_nxt;
  logic       groupOne_r;
  logic       groupOne_nxt;
  logic       groupTwo_r;
  logic       groupTwo_nxt;
  logic [NUM_CH-1:0] chClip_r;
  logic [NUM_CH-1:0] chClip_nxt;

  wire wrLatched = regWrEn && (regAddr == WARN_MASK_LATCHED_OFS);
  wire wrLive    = regWrEn && (regAddr == WARN_MASK_LIVE_OFS);
  wire wrClip    = regWrEn && (regAddr == CLIP_DETECT_CFG_OFS);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warnMaskLatched_r <= WARN_MASK_LATCHED_RST;
      warnMaskLive_r    <= WARN_MASK_LIVE_RST;
      clipDetectCfg_r   <= CLIP_DETECT_CFG_RST;
    end else if (clkEn) begin
      if (wrLatched) begin
        warnMaskLatched_r <= regWrData;
      end
      if (wrLive) begin
        warnMaskLive_r <= regWrData;
      end
      if (wrClip) begin
        clipDetectCfg_r <= regWrData;
      end
    end
  end

  // Reserved bits are writable storage but read back as stored
  assign regRdData = (regAddr == WARN_MASK_LATCHED_OFS) ? warnMaskLatched_r :
                     (regAddr == WARN_MASK_LIVE_OFS)    ? warnMaskLive_r :
                     (regAddr == CLIP_DETECT_CFG_OFS)   ? clipDetectCfg_r : 8'h00;

  // ----------------------------------------
  // Warning terms
  // ----------------------------------------
  wire [7:0] mL = warnMaskLatched_r;
  wire [7:0] mV = warnMaskLive_r;

  wire termClipSt   = mL[BIT_CLIP] && (|clipStored);
  wire termClockSt  = mL[BIT_CLOCK] && invalidClockStored;
  wire termOtsdSt   = mL[BIT_SHUTDOWN] && ((|overtempShutdownFlagStoredCh) || overtempShutdownFlagStored);
  wire termPowerSt  = mL[BIT_POWER] && (batteryUndervoltageFlagStored || batteryOvervoltageFlagStored ||
                      outputSupplyUndervoltageFlagStored || outputSupplyOvervoltageFlagStored ||
                      logicSupplyPorFlagStored || gateDriveSupplyFaultFlagStored);
  wire termOtwSt    = mL[BIT_TEMPWARN] && ((|overtempWarningFlagStoredCh) || overtempWarningFlagStored);
  wire termFoldSt   = mL[BIT_FOLDBACK] && gainFoldbackWarningFlagStored;
  wire termIlimSt   = mL[BIT_ILIMIT] && (|ilimitWarnStored);

  wire termClockLv  = mV[BIT_CLOCK] && invalidClock;
  wire termOtsdLv   = mV[BIT_SHUTDOWN] && ((|overtempShutdownFlagCh) || overtempShutdownFlag);
  // Logic-supply reset has no live term: that flag only exists latched
  wire termPowerLv  = mV[BIT_POWER] && (batteryUndervoltageFlag || batteryOvervoltageFlag ||
                      outputSupplyUndervoltageFlag || outputSupplyOvervoltageFlag ||
                      gateDriveSupplyFaultFlag);
  wire termOtwLv    = mV[BIT_TEMPWARN] && ((|overtempWarningFlagCh) || overtempWarningFlag);
  wire termFoldLv   = mV[BIT_FOLDBACK] && gainFoldbackWarningFlag;
  wire termDiag     = mV[BIT_DIAG] && !(&loadDiagDoneReport);

  assign warning_nxt = termClipSt | termClockSt | termOtsdSt | termPowerSt | termOtwSt | termFoldSt |
                       termIlimSt | termClockLv | termOtsdLv | termPowerLv | termOtwLv | termFoldLv |
                       termDiag;

  // ----------------------------------------
  // Clip groups
  // ----------------------------------------
  wire clipEn = clipDetectCfg_r[BIT_CLIP_EN];
  assign chClip_nxt = clipEn ? clipRaw : '0;
  wire clip12 = |chClip_nxt[1:0];
  wire clip34 = |chClip_nxt[NUM_CH-1:2];
  assign groupOne_nxt = (clipDetectCfg_r[BIT_C12_GRP1] && clip12) ||
                        (clipDetectCfg_r[BIT_C34_GRP1] && clip34);
  assign groupTwo_nxt = (clipDetectCfg_r[BIT_C12_GRP2] && clip12) ||
                        (clipDetectCfg_r[BIT_C34_GRP2] && clip34);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warning_r  <= 1'b0;
      groupOne_r <= 1'b0;
      groupTwo_r <= 1'b0;
      chClip_r   <= '0;
    end else if (clkEn) begin
      warning_r  <= warning_nxt;
      groupOne_r <= groupOne_nxt;
      groupTwo_r <= groupTwo_nxt;
      chClip_r   <= chClip_nxt;
    end
  end

  assign warningActive       = warning_r;
  assign clipGroupOne        = groupOne_r;
  assign clipGroupTwo        = groupTwo_r;
  assign channelClip         = chClip_r;
  assign clipDetectEnable    = clipEn;
  // The analog detector consumes the code; the mapping is fixed by the enum
  assign clipThresholdSelect = wcr_clip_lvl_e'(clipDetectCfg_r[BIT_LVL_HI:BIT_LVL_LO]);

  // ----------------------------------------
  // Output pin
  // ----------------------------------------
  // Warning takes the pin if several selects are raised at once
  wire drvOd   = pinSelWarning && warning_r;
  wire selPush = !pinSelWarning && (pinSelGroupOne || pinSelGroupTwo);
  wire pushVal = pinSelGroupOne ? groupOne_r : groupTwo_r;
  assign pinOut = selPush ? pushVal : 1'b0;
  assign pinOe  = drvOd || selPush;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_warn_clip_st: assert property (@(posedge clk) disable iff (rst)
    clkEn && mL[BIT_CLIP] && (|clipStored) |=> warningActive) else $error("clip stored missed");
  a_warn_clock_st: assert property (@(posedge clk) disable iff (rst)
    clkEn && mL[BIT_CLOCK] && invalidClockStored |=> warningActive) else $error("clock stored missed");
  a_warn_overtemp_shutdown_flag_lv: assert property (@(posedge clk) disable iff (rst)
    clkEn && mV[BIT_SHUTDOWN] && overtempShutdownFlag |=> warningActive) else $error("overtemp_shutdown_flag live missed");
  a_warn_por_live: assert property (@(posedge clk) disable iff (rst)
    clkEn && (mL == 8'h00) && (mV == 8'h08) && logicSupplyPorFlagStored && !batteryUndervoltageFlag &&
    !batteryOvervoltageFlag && !outputSupplyUndervoltageFlag && !outputSupplyOvervoltageFlag &&
    !gateDriveSupplyFaultFlag |=> !warningActive) else $error("por leaked live");
  a_warn_diag: assert property (@(posedge clk) disable iff (rst)
    clkEn && mV[BIT_DIAG] && !(&loadDiagDoneReport) |=> warningActive) else $error("diag missed");
  a_warn_idle: assert property (@(posedge clk) disable iff (rst)
    clkEn && !warning_nxt |=> !warningActive) else $error("spurious warning");
  a_clip_disabled: assert property (@(posedge clk) disable iff (rst)
    clkEn && !clipEn |=> !clipGroupOne && !clipGroupTwo && (channelClip == '0)) else $error("clip when off");
  a_grp_one_12: assert property (@(posedge clk) disable iff (rst)
    clkEn && clipEn && clipDetectCfg_r[BIT_C12_GRP1] && clipRaw[0] |=> clipGroupOne) else $error("grp1 missed");
  a_grp_two_34: assert property (@(posedge clk) disable iff (rst)
    clkEn && clipEn && clipDetectCfg_r[BIT_C34_GRP2] && clipRaw[3] |=> clipGroupTwo) else $error("grp2 missed");
  a_pin_warn_low: assert property (@(posedge clk) disable iff (rst)
    pinSelWarning && warningActive |-> pinOe && !pinOut) else $error("warn pin not low");
  a_pin_push: assert property (@(posedge clk) disable iff (rst)
    !pinSelWarning && pinSelGroupOne |-> pinOe && (pinOut == clipGroupOne)) else $error("push pin wrong");

  // ----------------------------------------
  // Stored warning sources
  // ----------------------------------------
  a_warn_overtemp_shutdown_flag_st: assert property (@(posedge clk) disable iff (rst)
    clkEn && mL[BIT_SHUTDOWN] && (|overtempShutdownFlagStoredCh)
    |=> warningActive)
    else $error("overtemp_shutdown_flag stored missed");

  a_warn_power_st: assert property (@(posedge clk) disable iff (rst)
    clkEn && mL[BIT_POWER] && logicSupplyPorFlagStored
    |=> warningActive)
    else $error("power stored missed");

  a_warn_otw_st: assert property (@(posedge clk) disable iff (rst)
    clkEn && mL[BIT_TEMPWARN] && (|overtempWarningFlagStoredCh)
    |=> warningActive)
    else $error("otw stored missed");

  a_warn_fold_st: assert property (@(posedge clk) disable iff (rst)
    clkEn && mL[BIT_FOLDBACK] && gainFoldbackWarningFlagStored
    |=> warningActive)
    else $error("foldback stored missed");

  a_warn_ilim_st: assert property (@(posedge clk) disable iff (rst)
    clkEn && mL[BIT_ILIMIT] && (|ilimitWarnStored)
    |=> warningActive)
    else $error("ilimit stored missed");

  // ----------------------------------------
  // Live warning sources
  // ----------------------------------------
  a_warn_clock_lv: assert property (@(posedge clk) disable iff (rst)
    clkEn && mV[BIT_CLOCK] && invalidClock
    |=> warningActive)
    else $error("clock live missed");

  a_warn_power_lv: assert property (@(posedge clk) disable iff (rst)
    clkEn && mV[BIT_POWER] && gateDriveSupplyFaultFlag
    |=> warningActive)
    else $error("power live missed");

  a_warn_otw_lv: assert property (@(posedge clk) disable iff (rst)
    clkEn && mV[BIT_TEMPWARN] && overtempWarningFlag
    |=> warningActive)
    else $error("otw live missed");

  a_warn_fold_lv: assert property (@(posedge clk) disable iff (rst)
    clkEn && mV[BIT_FOLDBACK] && gainFoldbackWarningFlag
    |=> warningActive)
    else $error("foldback live missed");

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  // A low enable must freeze the masks, or a stalled core could change routing
  a_mask_freeze: assert property (@(posedge clk) disable iff (rst)
    !clkEn
    |=> $stable(warnMaskLatched_r) && $stable(warnMaskLive_r) && $stable(clipDetectCfg_r))
    else $error("mask changed while frozen");

  a_latched_mask_wr: assert property (@(posedge clk) disable iff (rst)
    clkEn && wrLatched
    |=> warnMaskLatched_r == $past(regWrData))
    else $error("latched mask write lost");

  a_live_mask_wr: assert property (@(posedge clk) disable iff (rst)
    clkEn && wrLive
    |=> warnMaskLive_r == $past(regWrData))
    else $error("live mask write lost");

  a_clip_en_wr: assert property (@(posedge clk) disable iff (rst)
    clkEn && wrClip
    |=> clipDetectEnable == $past(regWrData[BIT_CLIP_EN]))
    else $error("clip enable write lost");

  a_clip_level_wr: assert property (@(posedge clk) disable iff (rst)
    clkEn && wrClip
    |=> clipThresholdSelect == $past(regWrData[BIT_LVL_HI:BIT_LVL_LO]))
    else $error("clip level write lost");

  // ----------------------------------------
  // Clip routing and pin
  // ----------------------------------------
  a_grp_one_34: assert property (@(posedge clk) disable iff (rst)
    clkEn && clipEn && clipDetectCfg_r[BIT_C34_GRP1] && clipRaw[2]
    |=> clipGroupOne)
    else $error("grp1 from ch3 missed");

  a_grp_two_12: assert property (@(posedge clk) disable iff (rst)
    clkEn && clipEn && clipDetectCfg_r[BIT_C12_GRP2] && clipRaw[1]
    |=> clipGroupTwo)
    else $error("grp2 from ch2 missed");

  a_ch_clip_pass: assert property (@(posedge clk) disable iff (rst)
    clkEn && clipEn
    |=> channelClip == $past(clipRaw))
    else $error("channel clip lost");

  a_pin_warn_off: assert property (@(posedge clk) disable iff (rst)
    pinSelWarning && !warningActive
    |-> !pinOe)
    else $error("warn pin driven idle");

  a_pin_push_two: assert property (@(posedge clk) disable iff (rst)
    !pinSelWarning && !pinSelGroupOne && pinSelGroupTwo
    |-> pinOe && (pinOut == clipGroupTwo))
    else $error("group two pin wrong");

  c_warn_raise: cover property (@(posedge clk) disable iff (rst) $rose(warningActive));
  c_diag_warn: cover property (@(posedge clk) disable iff (rst) termDiag ##1 warningActive);
  c_grp_one: cover property (@(posedge clk) disable iff (rst) $rose(clipGroupOne));
  c_grp_two: cover property (@(posedge clk) disable iff (rst) $rose(clipGroupTwo));
  c_cfg_write: cover property (@(posedge clk) disable iff (rst) clkEn && wrClip ##1 clipEn);
endmodule : wcr_routing

/* File: bench/warning_and_clip_signal_routing_bench.sv */
// Self-checking bench for the warning and clip signal routing block
`timescale 1ns/10ps
module warning_and_clip_signal_routing_bench;
  import wcr_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          clkEn = 1'b1;
  logic          regWrEn = 1'b0;
  logic [7:0]    regAddr = 8'h00;
  logic [7:0]    regWrData = 8'h00;
  logic [7:0]    regRdData;
  logic [42:0]   fv = '0;
  logic [3:0]    ldDone = 4'hF;
  logic [3:0]    clipRaw = 4'h0;
  logic          selW = 1'b0;
  logic          selG1 = 1'b0;
  logic          selG2 = 1'b0;
  logic          warningActive, clipGroupOne, clipGroupTwo, clipDetectEnable, pinOut, pinOe;
  logic [3:0]    channelClip;
  wcr_clip_lvl_e thr;
  int            fails = 0;
  int            totalChecks = 0;
  logic [7:0]    lm, vm;
  always #5 clk = ~clk;
  wcr_routing #(.NUM_CH(4)) i_dut (
    .clk(clk), .rst(rst), .clkEn(clkEn), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .clipStored(fv[3:0]), .invalidClockStored(fv[4]),
    .overtempShutdownFlagStoredCh(fv[8:5]), .overtempShutdownFlagStored(fv[9]),
    .batteryUndervoltageFlagStored(fv[10]), .batteryOvervoltageFlagStored(fv[11]),
    .outputSupplyUndervoltageFlagStored(fv[12]), .outputSupplyOvervoltageFlagStored(fv[13]),
    .logicSupplyPorFlagStored(fv[14]), .gateDriveSupplyFaultFlagStored(fv[15]),
    .overtempWarningFlagStoredCh(fv[19:16]), .overtempWarningFlagStored(fv[20]),
    .gainFoldbackWarningFlagStored(fv[21]), .ilimitWarnStored(fv[25:22]), .invalidClock(fv[26]),
    .overtempShutdownFlagCh(fv[30:27]), .overtempShutdownFlag(fv[31]), .batteryUndervoltageFlag(fv[32]),
    .batteryOvervoltageFlag(fv[33]), .outputSupplyUndervoltageFlag(fv[34]),
    .outputSupplyOvervoltageFlag(fv[35]), .gateDriveSupplyFaultFlag(fv[36]),
    .overtempWarningFlagCh(fv[40:37]), .overtempWarningFlag(fv[41]), .gainFoldbackWarningFlag(fv[42]),
    .loadDiagDoneReport(ldDone), .clipRaw(clipRaw), .pinSelWarning(selW), .pinSelGroupOne(selG1),
    .pinSelGroupTwo(selG2), .warningActive(warningActive), .clipGroupOne(clipGroupOne),
    .clipGroupTwo(clipGroupTwo), .channelClip(channelClip), .clipThresholdSelect(thr),
    .clipDetectEnable(clipDetectEnable), .pinOut(pinOut), .pinOe(pinOe)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge clk);
    regWrEn   <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    @(negedge clk);
    chk(regRdData, exp, "register read");
  endtask : rd
  // Registered outputs need one edge after the inputs change
  task automatic tick;
    @(posedge clk);
    @(negedge clk);
  endtask : tick
  function automatic logic expWarn(input logic [7:0] l, input logic [7:0] v, input logic [42:0] f,
                                   input logic [3:0] d);
    return (l[6] & |f[3:0]) | (l[5] & f[4]) | (l[4] & |f[9:5]) | (l[3] & |f[15:10]) | (l[2] & |f[20:16])
         | (l[1] & f[21]) | (l[0] & |f[25:22]) | (v[5] & f[26]) | (v[4] & |f[31:27]) | (v[3] & |f[36:32])
         | (v[2] & |f[41:37]) | (v[1] & f[42]) | (v[0] & ~&d);
  endfunction : expWarn
  task automatic final_report;
    if (fails == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(WARN_MASK_LATCHED_OFS, 8'h04);
    rd(WARN_MASK_LIVE_OFS, 8'h00);
    rd(CLIP_DETECT_CFG_OFS, 8'h00);
    chk({7'h0, warningActive}, 8'h00, "warning after reset");
    rd(8'h22, 8'h00);
    wr(WARN_MASK_LIVE_OFS, 8'hFF);
    rd(WARN_MASK_LIVE_OFS, 8'hFF);
    // Writes while the clock enable is low must be dropped
    clkEn <= 1'b0;
    wr(WARN_MASK_LIVE_OFS, 8'h12);
    clkEn <= 1'b1;
    rd(WARN_MASK_LIVE_OFS, 8'hFF);
    // One-hot masks against one-hot sources, including unfinished diagnostics
    for (int m = 0; m < 14; m++) begin
      lm = (m < 7) ? (8'h01 << m) : 8'h00;
      vm = (m < 7) ? 8'h00 : (8'h01 << (m - 7));
      wr(WARN_MASK_LATCHED_OFS, lm);
      wr(WARN_MASK_LIVE_OFS, vm);
      for (int b = 0; b < 44; b++) begin
        @(posedge clk);
        fv     <= (b < 43) ? (43'h1 << b) : '0;
        ldDone <= (b < 43) ? 4'hF : 4'hE;
        tick();
        chk({7'h0, warningActive}, {7'h0, expWarn(lm, vm, fv, ldDone)}, "warning term");
      end
    end
    // Open-drain warning pin pulls low while warning is active
    wr(WARN_MASK_LATCHED_OFS, 8'h04);
    @(posedge clk);
    fv     <= 43'h1 << 20;
    ldDone <= 4'hF;
    selW   <= 1'b1;
    tick();
    chk({6'h0, pinOe, pinOut}, 8'h02, "warning pin active");
    @(posedge clk);
    fv <= '0;
    tick();
    chk({7'h0, pinOe}, 8'h00, "warning pin released");
    @(posedge clk);
    selW  <= 1'b0;
    selG1 <= 1'b1;
    // Threshold codes
    for (int t = 0; t < 4; t++) begin
      wr(CLIP_DETECT_CFG_OFS, 8'h40 | (t << 4));
      @(negedge clk);
      chk({6'h0, thr}, t, "threshold code");
      chk({7'h0, clipDetectEnable}, 8'h01, "clip enable");
    end
    // Every routing code against each channel
    for (int r = 0; r < 16; r++) begin
      wr(CLIP_DETECT_CFG_OFS, 8'h40 | r);
      for (int c = 0; c < 4; c++) begin
        @(posedge clk);
        clipRaw <= 4'h1 << c;
        tick();
        chk({4'h0, channelClip}, 8'h01 << c, "channel clip");
        chk({7'h0, clipGroupOne}, (c < 2) ? r[0] : r[2], "group one");
        chk({7'h0, clipGroupTwo}, (c < 2) ? r[1] : r[3], "group two");
        chk({6'h0, pinOe, pinOut}, {7'h1, (c < 2) ? r[0] : r[2]}, "group pin");
      end
    end
    // Group two on the pin, routing still 0x4F
    @(posedge clk);
    selG1   <= 1'b0;
    selG2   <= 1'b1;
    clipRaw <= 4'h1;
    tick();
    chk({6'h0, pinOe, pinOut}, 8'h03, "group two pin");
    // Disabled detection silences everything whatever the routing
    wr(CLIP_DETECT_CFG_OFS, 8'h0F);
    @(posedge clk);
    clipRaw <= 4'hF;
    tick();
    chk({clipDetectEnable, clipGroupOne, clipGroupTwo, 1'b0, channelClip}, 8'h00, "clip disabled");
    final_report();
  end
endmodule : warning_and_clip_signal_routing_bench
